/* File: hdl/lid_decode_config.sv */
// legacy io decode configuration registers and address match logic
//
// Function
// - port B claimed and forwarded when its forward and monitor enables set
// - port B selector codes 0..7 pick the eight listed 8-byte windows
// - port A claimed and forwarded when its forward and monitor enables set
// - port A selector uses the same eight-window table as port B
// - generic chip select 1 low for device 10 hits when cs and forward set
// - device 10 claimed when its forward and monitor enables are set
// - device 10 monitor enable turns on base/mask decode for device 10
// - device 10 mask bits drop matching address bits 3..0 from compare
// - device 10 base compared against io address bits 15..0
// - device 12 monitor enable turns on its base/mask io decode
// - device 12 mask bits drop matching address bits 3..0 from compare
// - device 12 base compared against io address bits 15..0
`timescale 1ns/1ps

module lid_decode_config
  import lid_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire lid_cfg_req_s cfg_req,
  output logic [31:0]       cfg_rdata,
  output logic              cfg_rvalid,
  input  wire lid_io_req_s  io_req,
  input  wire logic         porta_monitor_enable,
  input  wire logic         portb_monitor_enable,
  input  wire logic         gen12_forward_enable,
  output lid_io_rsp_s       io_rsp,
  output logic              generic_chip_select_1_n
);

  logic [31:0] dec_c_q;
  logic [31:0] dec_e_q;
  logic [31:0] dec_f_q;
  logic [31:0] cfg_rdata_q;
  logic        cfg_rvalid_q;
  lid_io_rsp_s io_rsp_q;
  logic        cs_n_q;

  // merge a write into a register under byte enables and the writable mask
  function automatic logic [31:0] lid_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be,
                                            input logic [31:0] wm);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return ((old & ~bm) | (wd & bm)) & wm;
  endfunction

  logic sel_c;
  logic sel_e;
  logic sel_f;
  assign sel_c = (cfg_req.addr[7:2] == OFF_SER_GEN10[7:2]);
  assign sel_e = (cfg_req.addr[7:2] == OFF_GEN12_IO[7:2]);
  assign sel_f = (cfg_req.addr[7:2] == OFF_GEN12_MEM[7:2]);

  // register writes; reset clears every field so nothing is claimed
  always_ff @(posedge clk) begin
    if (rst) begin
      dec_c_q <= RST_SER_GEN10;
      dec_e_q <= RST_GEN12_IO;
      dec_f_q <= RST_GEN12_MEM;
    end else if (cfg_req.wr) begin
      if (sel_c) begin
        dec_c_q <= lid_merge(dec_c_q, cfg_req.wdata, cfg_req.be,
                             WMASK_SER_GEN10);
      end
      if (sel_e) begin
        dec_e_q <= lid_merge(dec_e_q, cfg_req.wdata, cfg_req.be,
                             WMASK_GEN12_IO);
      end
      if (sel_f) begin
        dec_f_q <= lid_merge(dec_f_q, cfg_req.wdata, cfg_req.be,
                             WMASK_GEN12_MEM);
      end
    end
  end

  // read data one cycle after the strobe; unmapped dwords read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_req.rd;
      if (cfg_req.rd) begin
        if (sel_c) begin
          cfg_rdata_q <= dec_c_q;
        end else if (sel_e) begin
          cfg_rdata_q <= dec_e_q;
        end else if (sel_f) begin
          cfg_rdata_q <= dec_f_q;
        end else begin
          cfg_rdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // field views
  logic        portb_forward_enable;
  logic [2:0]  portb_range_select;
  logic        porta_forward_enable;
  logic [2:0]  porta_range_select;
  logic        gen10_chip_select_enable;
  logic        gen10_forward_enable;
  logic        gen10_monitor_enable;
  logic [3:0]  gen10_address_mask;
  logic [15:0] gen10_base_address;
  logic        gen12_io_monitor_enable;
  logic [3:0]  gen12_io_address_mask;
  logic [15:0] gen12_io_base_address;

  assign portb_forward_enable     = dec_c_q[PB_FWD_BIT];
  assign portb_range_select       = dec_c_q[PB_SEL_LSB +: 3];
  assign porta_forward_enable     = dec_c_q[PA_FWD_BIT];
  assign porta_range_select       = dec_c_q[PA_SEL_LSB +: 3];
  assign gen10_chip_select_enable = dec_c_q[G10_CS_BIT];
  assign gen10_forward_enable     = dec_c_q[G10_FWD_BIT];
  assign gen10_monitor_enable     = dec_c_q[G10_MON_BIT];
  assign gen10_address_mask       = dec_c_q[MASK_LSB +: 4];
  assign gen10_base_address       = dec_c_q[BASE_LSB +: 16];
  assign gen12_io_monitor_enable  = dec_e_q[G12_MON_BIT];
  assign gen12_io_address_mask    = dec_e_q[MASK_LSB +: 4];
  assign gen12_io_base_address    = dec_e_q[BASE_LSB +: 16];

  // address compares; upper address bits always take part
  logic porta_in;
  logic portb_in;
  logic gen10_in;
  logic gen12_in;
  assign portb_in = (io_req.addr[15:SER_WIN_LSB] ==
                     SER_BASE[portb_range_select][15:SER_WIN_LSB]);
  assign porta_in = (io_req.addr[15:SER_WIN_LSB] ==
                     SER_BASE[porta_range_select][15:SER_WIN_LSB]);
  assign gen10_in = gen10_monitor_enable &&
                    (((io_req.addr ^ gen10_base_address) &
                      ~{12'h000, gen10_address_mask}) == 16'h0000);
  assign gen12_in = gen12_io_monitor_enable &&
                    (((io_req.addr ^ gen12_io_base_address) &
                      ~{12'h000, gen12_io_address_mask}) == 16'h0000);

  logic porta_claim;
  logic portb_claim;
  logic gen10_claim;
  logic gen12_claim;
  assign portb_claim = portb_in && portb_forward_enable &&
                       portb_monitor_enable;
  assign porta_claim = porta_in && porta_forward_enable &&
                       porta_monitor_enable;
  assign gen10_claim = gen10_in && gen10_forward_enable;
  // device 12 forwarding needs its enable from outside this block
  assign gen12_claim = gen12_in && gen12_forward_enable;

  // answer registered one cycle after each io request
  always_ff @(posedge clk) begin
    if (rst) begin
      io_rsp_q <= '0;
    end else begin
      io_rsp_q.done      <= io_req.valid;
      io_rsp_q.portb_hit <= io_req.valid && portb_claim;
      io_rsp_q.porta_hit <= io_req.valid && porta_claim;
      io_rsp_q.gen10_hit <= io_req.valid && gen10_in;
      io_rsp_q.gen12_hit <= io_req.valid && gen12_in;
      io_rsp_q.claim     <= io_req.valid &&
                            (portb_claim || porta_claim ||
                             gen10_claim || gen12_claim);
    end
  end

  // chip select is a one-cycle low pulse aligned with the answer
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_n_q <= 1'b1;
    end else begin
      cs_n_q <= !(io_req.valid && gen10_claim &&
                  gen10_chip_select_enable);
    end
  end

  assign cfg_rdata               = cfg_rdata_q;
  assign cfg_rvalid              = cfg_rvalid_q;
  assign io_rsp                  = io_rsp_q;
  assign generic_chip_select_1_n = cs_n_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_io(logic [15:0] lo);
    io_req.valid && io_req.addr[15:SER_WIN_LSB] == lo[15:SER_WIN_LSB];
  endsequence

  property p_portb_claim;
    s_io(SER_BASE[portb_range_select]) and
    (portb_forward_enable && portb_monitor_enable) |=> io_rsp.claim;
  endproperty
  a_portb_claim: assert property (p_portb_claim)
    else $error("port B access not claimed");

  property p_portb_off;
    io_req.valid && !portb_monitor_enable && !porta_claim &&
    !gen10_claim && !gen12_claim |=> !io_rsp.claim && !io_rsp.portb_hit;
  endproperty
  a_portb_off: assert property (p_portb_off)
    else $error("port B claimed without monitor enable");

  property p_portb_com1;
    io_req.valid && portb_forward_enable && portb_monitor_enable &&
    portb_range_select == 3'h0 && io_req.addr == 16'h03ff
    |=> io_rsp.portb_hit;
  endproperty
  a_portb_com1: assert property (p_portb_com1)
    else $error("port B code 0 top byte missed");

  property p_porta_claim;
    s_io(SER_BASE[porta_range_select]) and
    (porta_forward_enable && porta_monitor_enable) |=> io_rsp.porta_hit;
  endproperty
  a_porta_claim: assert property (p_porta_claim)
    else $error("port A access not claimed");

  property p_porta_com3;
    io_req.valid && porta_forward_enable && porta_monitor_enable &&
    porta_range_select == 3'h7 && io_req.addr == 16'h03f0
    |=> !io_rsp.porta_hit;
  endproperty
  a_porta_com3: assert property (p_porta_com3)
    else $error("port A code 7 hit outside its window");

  // low for the answer cycle, back high unless another request followed
  sequence s_cs_pulse;
    !generic_chip_select_1_n ##1
    (generic_chip_select_1_n || $past(io_req.valid));
  endsequence

  property p_cs_pulse;
    io_req.valid && gen10_in && gen10_forward_enable &&
    gen10_chip_select_enable |=> s_cs_pulse;
  endproperty
  a_cs_pulse: assert property (p_cs_pulse)
    else $error("chip select pulse wrong");

  property p_cs_needs_fwd;
    !generic_chip_select_1_n |-> io_rsp.gen10_hit && io_rsp.claim;
  endproperty
  a_cs_needs_fwd: assert property (p_cs_needs_fwd)
    else $error("chip select without forwarded hit");

  property p_gen10_claim;
    io_req.valid && gen10_in && gen10_forward_enable |=> io_rsp.claim;
  endproperty
  a_gen10_claim: assert property (p_gen10_claim)
    else $error("device 10 access not claimed");

  property p_gen10_mon;
    io_req.valid && !gen10_monitor_enable |=> !io_rsp.gen10_hit;
  endproperty
  a_gen10_mon: assert property (p_gen10_mon)
    else $error("device 10 hit with monitor off");

  property p_gen10_mask;
    io_req.valid && gen10_monitor_enable &&
    io_req.addr[15:4] == gen10_base_address[15:4] &&
    ((io_req.addr[3:0] ^ gen10_base_address[3:0]) &
     ~gen10_address_mask) == 4'h0 |=> io_rsp.gen10_hit;
  endproperty
  a_gen10_mask: assert property (p_gen10_mask)
    else $error("device 10 masked compare failed");

  property p_gen10_base;
    io_req.valid && io_req.addr[15:4] != gen10_base_address[15:4]
    |=> !io_rsp.gen10_hit;
  endproperty
  a_gen10_base: assert property (p_gen10_base)
    else $error("device 10 hit outside base");

  property p_gen12_hit;
    io_req.valid && gen12_io_monitor_enable &&
    io_req.addr == gen12_io_base_address |=> io_rsp.gen12_hit;
  endproperty
  a_gen12_hit: assert property (p_gen12_hit)
    else $error("device 12 base address missed");

  property p_gen12_mask;
    io_req.valid && gen12_io_monitor_enable &&
    io_req.addr[15:4] == gen12_io_base_address[15:4] &&
    ((io_req.addr[3:0] ^ gen12_io_base_address[3:0]) &
     ~gen12_io_address_mask) != 4'h0 |=> !io_rsp.gen12_hit;
  endproperty
  a_gen12_mask: assert property (p_gen12_mask)
    else $error("device 12 unmasked bit ignored");

  property p_gen12_base;
    io_req.valid && io_req.addr[15:4] != gen12_io_base_address[15:4]
    |=> !io_rsp.gen12_hit;
  endproperty
  a_gen12_base: assert property (p_gen12_base)
    else $error("device 12 hit outside base");

  property p_rsvd;
    (dec_c_q & ~WMASK_SER_GEN10) == 32'h0 &&
    (dec_e_q & ~WMASK_GEN12_IO) == 32'h0 &&
    (dec_f_q & ~WMASK_GEN12_MEM) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");

  property p_reset_clear;
    $past(rst) |-> dec_c_q == 32'h0 && dec_e_q == 32'h0 &&
    dec_f_q == 32'h0 && generic_chip_select_1_n;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("fields not cleared by reset");

endmodule // lid_decode_config

/* File: shared/lid_pkg.sv */
// package: offsets, field layout, reset values and carriers for the io decoder
package lid_pkg;

  // configuration dword offsets
  localparam logic [7:0]  OFF_SER_GEN10   = 8'h64;
  localparam logic [7:0]  OFF_GEN12_IO    = 8'h68;
  localparam logic [7:0]  OFF_GEN12_MEM   = 8'h6c;

  // values after reset
  localparam logic [31:0] RST_SER_GEN10   = 32'h0000_0000;
  localparam logic [31:0] RST_GEN12_IO    = 32'h0000_0000;
  localparam logic [31:0] RST_GEN12_MEM   = 32'h0000_0000;

  // writable bits; reserved bits are held at zero
  localparam logic [31:0] WMASK_SER_GEN10 = 32'hffef_ffff;
  localparam logic [31:0] WMASK_GEN12_IO  = 32'h001f_ffff;
  localparam logic [31:0] WMASK_GEN12_MEM = 32'hffff_80ff;

  // field positions, serial_and_generic10_decode
  localparam int PB_FWD_BIT   = 31;
  localparam int PB_SEL_LSB   = 28;
  localparam int PA_FWD_BIT   = 27;
  localparam int PA_SEL_LSB   = 24;
  localparam int G10_CS_BIT   = 23;
  localparam int G10_FWD_BIT  = 22;
  localparam int G10_MON_BIT  = 21;
  // shared by both generic io registers
  localparam int MASK_LSB     = 16;
  localparam int BASE_LSB     = 0;
  // generic12_io_decode
  localparam int G12_MON_BIT  = 20;

  // serial windows are eight bytes: low three address bits are ignored
  localparam int SER_WIN_LSB  = 3;

  // serial range table, index is the three bit range selector
  localparam logic [7:0][15:0] SER_BASE = {
    16'h03e8, 16'h0338, 16'h02e8, 16'h0238,
    16'h0228, 16'h0220, 16'h02f8, 16'h03f8
  };

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } lid_cfg_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } lid_io_req_s;

  typedef struct packed {
    logic done;
    logic claim;
    logic porta_hit;
    logic portb_hit;
    logic gen10_hit;
    logic gen12_hit;
  } lid_io_rsp_s;

endpackage

/* File: bench/lid_io_host.sv */
// io cycle issuer standing in for the pci host side of the decoder
`timescale 1ns/1ps

module lid_io_host
  import lid_pkg::*;
(
  input  wire logic        clk,
  output lid_io_req_s      io_req,
  input  wire lid_io_rsp_s io_rsp,
  input  wire logic        generic_chip_select_1_n
);
  initial io_req = '0;

  // one cycle pulse; the answer is registered, so read it at the next falling edge, one cycle later
  task automatic io_cycle(input logic [15:0] a, output lid_io_rsp_s r,
                          output logic cs_n);
    @(negedge clk);
    io_req = '{valid: 1'b1, addr: a};
    @(negedge clk);
    // the address does not linger once valid drops
    io_req = '{valid: 1'b0, addr: ~a};
    r = io_rsp;
    cs_n = generic_chip_select_1_n;
  endtask
endmodule // lid_io_host

/* File: bench/testbench.sv */
// self-checking bench for the legacy io decode configuration block
`timescale 1ns/1ps

module testbench
  import lid_pkg::*;
();
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  lid_cfg_req_s cfg_req = '0;
  logic [31:0]  cfg_rdata;
  logic         cfg_rvalid;
  lid_io_req_s  io_req;
  logic         porta_monitor_enable = 1'b1;
  logic         portb_monitor_enable = 1'b1;
  logic         gen12_forward_enable = 1'b1;
  lid_io_rsp_s  io_rsp;
  logic         cs_n;
  int           miscompares = 0;
  int           check_count = 0;
  logic [15:0]  ser_exp [8] = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228,
                                16'h0238, 16'h02e8, 16'h0338, 16'h03e8};

  always #12.5 clk = ~clk;

  lid_decode_config i_lid_decode_config (
    .clk                     (clk),
    .rst                     (rst),
    .cfg_req                 (cfg_req),
    .cfg_rdata               (cfg_rdata),
    .cfg_rvalid              (cfg_rvalid),
    .io_req                  (io_req),
    .porta_monitor_enable    (porta_monitor_enable),
    .portb_monitor_enable    (portb_monitor_enable),
    .gen12_forward_enable    (gen12_forward_enable),
    .io_rsp                  (io_rsp),
    .generic_chip_select_1_n (cs_n)
  );

  lid_io_host i_lid_io_host (
    .clk                     (clk),
    .io_req                  (io_req),
    .io_rsp                  (io_rsp),
    .generic_chip_select_1_n (cs_n)
  );

  task automatic final_report();
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, seen,
               exp);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    @(negedge clk);
    cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(negedge clk);
    cfg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
  endtask

  // read strobe for one cycle, answer stands in the following cycle
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: '0};
    @(negedge clk);
    cfg_req.rd = 1'b0;
    check({cfg_rvalid, cfg_rdata[30:0]}, {1'b1, exp[30:0]}, "read");
    check({31'h0, cfg_rdata[31]}, {31'h0, exp[31]}, "read msb");
  endtask

  // expected flags: claim, port a, port b, dev10, dev12, chip select
  task automatic io_chk(input logic [15:0] a, input logic [5:0] exp);
    lid_io_rsp_s r;
    logic        c;
    i_lid_io_host.io_cycle(a, r, c);
    check({25'h0, r, c}, {25'h0, 1'b1, exp}, "io decode");
  endtask

  task automatic t_reset();
    cfg_rd(8'h64, 32'h0);
    cfg_rd(8'h68, 32'h0);
    cfg_rd(8'h6c, 32'h0);
    io_chk(16'h03f8, 6'b000001);
  endtask

  // reset in mid-run with fields set must clear them all again
  task automatic t_reset_mid();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset();
  endtask

  task automatic t_regs();
    cfg_wr(8'h64, 4'hf, 32'hffff_ffff);
    cfg_wr(8'h68, 4'hf, 32'hffff_ffff);
    cfg_wr(8'h6c, 4'hf, 32'hffff_ffff);
    cfg_wr(8'h70, 4'hf, 32'hffff_ffff);
    cfg_rd(8'h64, 32'hffef_ffff);
    cfg_rd(8'h68, 32'h001f_ffff);
    cfg_rd(8'h6c, 32'hffff_80ff);
    cfg_rd(8'h70, 32'h0);
    cfg_wr(8'h68, 4'h2, 32'h0);
    cfg_rd(8'h68, 32'h001f_00ff);
    cfg_wr(8'h68, 4'hf, 32'h0);
  endtask

  // port b uses code i, port a the opposite code, so windows never overlap
  task automatic t_serial();
    for (int i = 0; i < 8; i++) begin
      cfg_wr(8'h64, 4'hf, {1'b1, 3'(i), 1'b1, 3'(7 - i), 24'h0});
      io_chk(ser_exp[i] + 16'h7, 6'b101001);
      io_chk(ser_exp[i] + 16'h8, 6'b000001);
      io_chk(ser_exp[7 - i], 6'b110001);
      io_chk(ser_exp[7 - i] + 16'h8, 6'b000001);
    end
    portb_monitor_enable = 1'b0;
    io_chk(16'h03e8, 6'b000001);
    portb_monitor_enable = 1'b1;
    porta_monitor_enable = 1'b0;
    io_chk(16'h03f8, 6'b000001);
    porta_monitor_enable = 1'b1;
    cfg_wr(8'h64, 4'hf, 32'h1000_0000);
    io_chk(16'h02f8, 6'b000001);
    io_chk(16'h03f8, 6'b000001);
  endtask

  // mask 1001 splits the window into 300-301 and 308-309
  task automatic t_gen10();
    logic h;
    cfg_wr(8'h64, 4'hf, 32'h00e9_0300);
    for (int k = 0; k <= 16; k++) begin
      h = (((16'h0300 + 16'(k)) ^ 16'h0300) & 16'hfff6) == 16'h0;
      io_chk(16'h0300 + 16'(k), {h, 2'b00, h, 1'b0, !h});
    end
    cfg_wr(8'h64, 4'hf, 32'h00a9_0300);
    io_chk(16'h0301, 6'b000101);
    cfg_wr(8'h64, 4'hf, 32'h0069_0300);
    io_chk(16'h0308, 6'b100101);
    cfg_wr(8'h64, 4'hf, 32'h00c9_0300);
    io_chk(16'h0300, 6'b000001);
  endtask

  task automatic t_gen12();
    logic h;
    cfg_wr(8'h68, 4'hf, 32'h0016_0510);
    for (int f = 1; f >= 0; f--) begin
      gen12_forward_enable = f[0];
      for (int k = 0; k <= 16; k++) begin
        h = (((16'h0510 + 16'(k)) ^ 16'h0510) & 16'hfff9) == 16'h0;
        io_chk(16'h0510 + 16'(k), {h & f[0], 3'b000, h, 1'b1});
      end
    end
    gen12_forward_enable = 1'b1;
    cfg_wr(8'h68, 4'hf, 32'h0006_0510);
    io_chk(16'h0510, 6'b000001);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_serial();
    t_gen10();
    t_gen12();
    t_reset_mid();
    final_report();
  end

  // guards against a hang; the run needs far fewer cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule // testbench
